// ==== trace_pkg.sv ====
// Constants and carrier types for the trace buffer format and read-out block.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
// How it works
// RULE_01 - Normal/loop rows: bit 3 is 0 for a source and 1 for a destination.
// RULE_02 - Bit 2 marks vector destinations; a vector row also sets the destination bit.
// RULE_03 - Normal/loop rows: bits 1 and 0 hold address bits 17 and 16.
// RULE_04 - Compressed row with code 00 holds a full 18-bit base address.
// RULE_05 - Codes 01, 10, 11 hold one, two, three 6-bit offsets from base.
// RULE_06 - A new base is stored whenever address bits 17:6 leave the base range.
// RULE_07 - Compressed mode always writes a base into line 0, also after wrapping.
// RULE_08 - Reads work only when disarmed, source selected and not secured.
// RULE_09 - Arming locks reads; an aligned word write to data register unlocks.
// RULE_10 - Only aligned word reads of the data register; others return 0, no step.
// RULE_11 - Lines come out oldest first; the valid-line count never decrements on reads.
// RULE_12 - After a session the read pointer is line 0, or oldest line after wrap.
// RULE_13 - Buffer-full flag reports that writing has wrapped round.
// RULE_14 - Reader decodes the oldest wrapped compressed line from its code bits.
// RULE_15 - Aligned word write to the high data address restarts reading at oldest.
// RULE_16 - First word of a line gives fields 1,0; second gives field 2 in bits 3:0.
// RULE_17 - Reads while armed give invalid data and leave the pointer alone.
// RULE_18 - System reset keeps contents, count and pointers; unlock finds oldest. Code resets the read pointer to line 0 and keeps head.
// RULE_19 - With the source select clear, reads return all zeroes.
// RULE_20 - Contents and count need no power-on initialisation.
// RULE_21 - Reader restarts flow reconstruction at the first base after the pointer.
// RULE_22 - Compressed rows are two code bits then eighteen address bits.
// RULE_23 - Detail mode stores address then data lines; count steps twice.
// RULE_24 - Read pointer steps after both words of a line, wrapping at the end.
package trace_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TRACE_DATA_OFS = 8'h04;
  localparam logic [7:0] TRACE_DATA_HIGH_OFS = 8'h08;
  localparam logic [7:0] TRACE_COUNT_OFS = 8'h0C;

  // Control register fields
  localparam int ARM_BIT = 0;
  localparam int TSRC_BIT = 1;
  localparam int MODE_LSB = 2;
  // Count register fields
  localparam int FULL_BIT = 7;
  localparam int LOCKED_BIT = 8;

  // ------------------------------------------------------------
  // Buffer geometry
  // ------------------------------------------------------------
  localparam int LINES = 64;
  localparam int ROW_W = 20;
  localparam logic [5:0] LAST_LINE = 6'h3F;
  localparam logic [6:0] FULL_COUNT = 7'h40;
  localparam logic [1:0] CODE_BASE = 2'h0;
  localparam logic [1:0] CODE_ONE = 2'h1;
  localparam logic [1:0] CODE_TWO = 2'h2;
  localparam logic [1:0] CODE_THREE = 2'h3;

  // Reset values
  localparam logic [5:0] RPTR_RST = 6'h00;
  localparam logic [1:0] MODE_RST = 2'h0;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_LOOP,
    MODE_DETAIL,
    MODE_COMPRESSED
  } trace_mode_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic valid;
    logic [17:0] pc;
    logic dest;
    logic vector;
    logic size_byte;
    logic read;
    logic [15:0] data;
  } trace_evt_t;

endpackage

// ==== trace_buffer_format_readout.sv ====
// Trace buffer: row formatting for all trace modes, compressed PC encoding,
// and the locked, word-wise APB read path.
// Assumes trace events and APB signals are synchronous to CLK_I.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module trace_buffer_format_readout
  import trace_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire apb_req_t APB_I,
  input wire trace_evt_t TRACE_I,
  input wire logic DISARM_I,
  input wire logic SECURE_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  output logic ARMED_O
);

  typedef struct packed {
    logic arm;
    logic tsrc;
    trace_mode_t mode;
    logic unlocked;
    logic [5:0] rptr;
    logic half;
    logic [5:0] head;
    logic [6:0] cnt;
    logic full;
    logic base_valid;
    logic [11:0] base_hi;
    logic [1:0] inc_cnt;
    logic [17:0] open_row;
    logic dpend;
    logic [15:0] ddata;
    logic last_valid;
    logic [17:0] last_pc;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [ROW_W-1:0] mem [LINES];
  logic we;
  logic [5:0] waddr;
  logic [ROW_W-1:0] wdata;

  function automatic logic [5:0] line_inc(input logic [5:0] p);
    line_inc = (p == LAST_LINE) ? 6'h00 : p + 6'h01;
  endfunction

  function automatic logic [5:0] oldest_line(input state_t s);
    oldest_line = s.full ? s.head : RPTR_RST;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic new_line;
  logic need_base;
  logic access;
  logic done;
  logic word_wr;
  logic read_ok;
  logic [ROW_W-1:0] rd_row;
  logic [31:0] rd_val;

  always_comb begin
    s_next = s_reg;
    we = 1'b0;
    waddr = s_reg.head;
    wdata = '0;
    new_line = 1'b0;
    need_base = 1'b0;
    rd_row = mem[s_reg.rptr];
    rd_val = 32'h0000_0000;
    access = APB_I.psel && APB_I.penable;
    done = access && s_reg.pready;
    word_wr = APB_I.pwrite && (APB_I.paddr[1:0] == 2'h0) && (APB_I.pstrb == 4'hF);
    read_ok = !s_reg.arm && s_reg.tsrc && !SECURE_I && s_reg.unlocked; // see RULE_08

    // ----------------------------------------------------------
    // Trace capture
    // ----------------------------------------------------------
    if (s_reg.arm) begin
      case (s_reg.mode)
        MODE_NORMAL, MODE_LOOP: begin
          if (TRACE_I.valid && !(s_reg.mode == MODE_LOOP && !TRACE_I.dest
              && s_reg.last_valid && TRACE_I.pc == s_reg.last_pc)) begin
            we = 1'b1;
            new_line = 1'b1;
            // Vector rows force the destination bit
            wdata = {TRACE_I.dest | TRACE_I.vector, TRACE_I.vector, // see RULE_01 see RULE_02
                     TRACE_I.pc[17:16], TRACE_I.pc[15:0]}; // see RULE_03
            s_next.last_valid = 1'b1;
            s_next.last_pc = TRACE_I.pc;
          end
        end
        MODE_DETAIL: begin
          // Address line then data line, one line per cycle
          if (s_reg.dpend) begin
            we = 1'b1;
            new_line = 1'b1; // see RULE_23
            wdata = {4'h0, s_reg.ddata};
            s_next.dpend = 1'b0;
          end else if (TRACE_I.valid) begin
            we = 1'b1;
            new_line = 1'b1; // see RULE_23
            wdata = {TRACE_I.size_byte, TRACE_I.read, TRACE_I.pc};
            s_next.dpend = 1'b1;
            s_next.ddata = TRACE_I.data;
          end
        end
        MODE_COMPRESSED: begin
          if (TRACE_I.valid) begin
            need_base = !s_reg.base_valid || (TRACE_I.pc[17:6] != s_reg.base_hi); // see RULE_06
            if (need_base || (s_reg.inc_cnt == 2'h0 && s_reg.head == 6'h00)) begin
              // Base row, also forced whenever line 0 is started
              we = 1'b1;
              new_line = 1'b1;
              wdata = {CODE_BASE, TRACE_I.pc}; // see RULE_04 see RULE_07 see RULE_22
              s_next.base_valid = 1'b1;
              s_next.base_hi = TRACE_I.pc[17:6];
              s_next.inc_cnt = 2'h0;
            end else if (s_reg.inc_cnt == 2'h0) begin
              we = 1'b1;
              new_line = 1'b1;
              s_next.open_row = {12'h000, TRACE_I.pc[5:0]};
              wdata = {CODE_ONE, 12'h000, TRACE_I.pc[5:0]}; // see RULE_05
              s_next.inc_cnt = 2'h1;
            end else if (s_reg.inc_cnt == 2'h1) begin
              // Open line sits just behind head
              we = 1'b1;
              waddr = s_reg.head - 6'h01;
              s_next.open_row = {6'h00, TRACE_I.pc[5:0], s_reg.open_row[5:0]};
              wdata = {CODE_TWO, 6'h00, TRACE_I.pc[5:0], s_reg.open_row[5:0]}; // see RULE_05
              s_next.inc_cnt = 2'h2;
            end else begin
              we = 1'b1;
              waddr = s_reg.head - 6'h01;
              wdata = {CODE_THREE, TRACE_I.pc[5:0], s_reg.open_row[11:0]}; // see RULE_05
              s_next.inc_cnt = 2'h0;
            end
          end
        end
        default: begin
          we = 1'b0;
        end
      endcase
    end

    if (new_line) begin
      s_next.head = line_inc(s_reg.head);
      if (s_reg.head == LAST_LINE) begin
        s_next.full = 1'b1; // see RULE_13
      end
      if (s_reg.cnt != FULL_COUNT) begin
        s_next.cnt = s_reg.cnt + 7'h01;
      end
    end

    if (DISARM_I) begin
      s_next.arm = 1'b0;
    end

    // ----------------------------------------------------------
    // Read data for the access phase
    // ----------------------------------------------------------
    // Word decode, so a misaligned data read reaches its own refusal
    case ({APB_I.paddr[7:2], 2'h0})
      CTRL_OFS: rd_val = {28'h0, s_reg.mode, s_reg.tsrc, s_reg.arm};
      TRACE_DATA_OFS: begin
        if (APB_I.paddr[1:0] != 2'h0 || !s_reg.tsrc) begin
          rd_val = 32'h0000_0000; // see RULE_10 see RULE_19
        end else if (s_reg.arm) begin
          rd_val = {12'h000, rd_row}; // see RULE_17
        end else if (read_ok) begin
          rd_val = s_reg.half ? {28'h0, rd_row[19:16]} // see RULE_16
                              : {16'h0, rd_row[15:0]};
        end
      end
      TRACE_DATA_HIGH_OFS: rd_val = 32'h0000_0000;
      TRACE_COUNT_OFS: begin
        rd_val = {23'h0, !s_reg.unlocked, s_reg.full, s_reg.cnt}; // see RULE_11 see RULE_13
      end
      default: rd_val = 32'h0000_0000;
    endcase

    // ----------------------------------------------------------
    // APB slave: answer one cycle into the access phase
    // ----------------------------------------------------------
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (access && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.prdata = APB_I.pwrite ? 32'h0000_0000 : rd_val;
      // Only the four words are mapped; low address bits alone never error
      s_next.pslverr = (APB_I.paddr[7:4] != 4'h0);
    end

    if (done && APB_I.pwrite) begin
      case (APB_I.paddr)
        CTRL_OFS: begin
          if (APB_I.pstrb[0]) begin
            s_next.tsrc = APB_I.pwdata[TSRC_BIT];
            s_next.mode = trace_mode_t'(APB_I.pwdata[MODE_LSB +: 2]);
            s_next.arm = APB_I.pwdata[ARM_BIT];
            if (APB_I.pwdata[ARM_BIT] && !s_reg.arm) begin
              // New session: lock reads and restart recording
              s_next.unlocked = 1'b0; // see RULE_09
              s_next.head = 6'h00;
              s_next.cnt = 7'h00;
              s_next.full = 1'b0;
              s_next.base_valid = 1'b0;
              s_next.inc_cnt = 2'h0;
              s_next.dpend = 1'b0;
              s_next.last_valid = 1'b0;
            end
          end
        end
        TRACE_DATA_OFS: begin
          if (word_wr && !s_reg.arm) begin
            s_next.unlocked = 1'b1; // see RULE_09
            s_next.rptr = oldest_line(s_reg); // see RULE_12 see RULE_18
            s_next.half = 1'b0;
          end
        end
        TRACE_DATA_HIGH_OFS: begin
          if (word_wr && !s_reg.arm) begin
            s_next.rptr = oldest_line(s_reg); // see RULE_15
            s_next.half = 1'b0;
          end
        end
        default: begin
          s_next.half = s_reg.half;
        end
      endcase
    end

    if (done && !APB_I.pwrite && APB_I.paddr == TRACE_DATA_OFS && read_ok) begin
      // Second word of a line moves on to the next line
      s_next.half = !s_reg.half;
      if (s_reg.half) begin
        s_next.rptr = line_inc(s_reg.rptr); // see RULE_24 see RULE_11
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg <= s_next;
      s_reg.arm <= 1'b0;
      s_reg.tsrc <= 1'b0;
      s_reg.mode <= trace_mode_t'(MODE_RST);
      s_reg.unlocked <= 1'b0;
      s_reg.rptr <= RPTR_RST;
      s_reg.half <= 1'b0;
      // Head, count and full flag survive a system reset
      s_reg.head <= s_reg.head; // see RULE_18
      s_reg.cnt <= s_reg.cnt; // see RULE_18
      s_reg.full <= s_reg.full;
      s_reg.base_valid <= 1'b0;
      s_reg.base_hi <= 12'h000;
      s_reg.inc_cnt <= 2'h0;
      s_reg.open_row <= 18'h00000;
      s_reg.dpend <= 1'b0;
      s_reg.ddata <= 16'h0000;
      s_reg.last_valid <= 1'b0;
      s_reg.last_pc <= 18'h00000;
      s_reg.pready <= 1'b0;
      s_reg.prdata <= 32'h0000_0000;
      s_reg.pslverr <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Buffer RAM is never cleared
  always_ff @(posedge CLK_I) begin
    if (we && !RST_I) begin
      mem[waddr] <= wdata; // see RULE_20
    end
  end

  assign PREADY_O = s_reg.pready;
  assign PRDATA_O = s_reg.prdata;
  assign PSLVERR_O = s_reg.pslverr;
  assign ARMED_O = s_reg.arm;

endmodule

// ==== trace_buffer_format_readout_assertions.sv ====
// Port checks for the trace buffer read-out block.
// Assumes trace_pkg is compiled first; bound to the top module below.
`timescale 1ns/10ps
module trace_buffer_format_readout_assertions
  import trace_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire apb_req_t APB_I,
  input wire logic DISARM_I,
  input wire logic SECURE_I,
  input wire logic PREADY_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire logic ARMED_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic rd_data;
  logic ctrl_wr;
  assign rd_data = PREADY_O && !APB_I.pwrite && APB_I.paddr[7:2] == 6'h01;
  assign ctrl_wr = PREADY_O && APB_I.pwrite && APB_I.paddr == CTRL_OFS;
  // ------------------------------------------------------------
  // Bus timing and decode
  // ------------------------------------------------------------
  sequence access_start;
    $rose(APB_I.penable) && APB_I.psel;
  endsequence
  sequence one_wait;
    !PREADY_O ##1 PREADY_O;
  endsequence
  ready_wait_a: assert property (access_start |-> one_wait)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (PREADY_O |-> PSLVERR_O == (APB_I.paddr[7:4] != 4'h0))
    else $error("error response wrong for address");
  // ------------------------------------------------------------
  // Arm lock and read data
  // ------------------------------------------------------------
  arm_set_a: assert property (ctrl_wr && APB_I.pwdata[ARM_BIT] && !DISARM_I |=> ARMED_O)
    else $error("arm write did not arm");
  disarm_clear_a: assert property (DISARM_I && !ctrl_wr |=> !ARMED_O)
    else $error("disarm did not clear arm");
  arm_hold_a: assert property (!DISARM_I && !ctrl_wr |=> $stable(ARMED_O))
    else $error("arm changed without cause");
  secure_zero_a: assert property (rd_data && SECURE_I && !ARMED_O |-> PRDATA_O == 32'h0)
    else $error("secured read not zero");
  misalign_zero_a: assert property (rd_data && APB_I.paddr[1:0] != 2'h0 |-> PRDATA_O == 32'h0)
    else $error("misaligned read not zero");
  upper_zero_a: assert property (rd_data && !ARMED_O |-> PRDATA_O[31:16] == 16'h0)
    else $error("read data upper half not zero");
endmodule
bind trace_buffer_format_readout trace_buffer_format_readout_assertions u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .APB_I(APB_I), .DISARM_I(DISARM_I), .SECURE_I(SECURE_I),
  .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .ARMED_O(ARMED_O));

// ==== debug_host_model.sv ====
// Debug host model: APB master that reads the trace buffer out.
// Assumes it shares the block clock; its tasks are called from the bench.
`timescale 1ns/10ps
module debug_host_model
  import trace_pkg::*;
(
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i,
  output apb_req_t apb_o
);
  initial apb_o = '0;
  // Entered just after a rising edge; leaves one edge after the answering edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    apb_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d,
               pstrb: (w ? 4'hF : 4'h0)};
    @(posedge clk_i);
    apb_o.penable <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    apb_o.psel <= 1'b0;
    apb_o.penable <= 1'b0;
    // Idle edge, so the next setup is not assigned in the same step
    @(posedge clk_i);
  endtask
  task automatic unlock();
    logic [31:0] r;
    logic e;
    xfer(1'b1, TRACE_DATA_OFS, 32'h0, r, e);
  endtask
endmodule

// ==== trace_buffer_format_readout_tb_top.sv ====
// Self-checking bench for the trace buffer read-out block.
// Assumes trace_pkg, the design and the host model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module trace_buffer_format_readout_tb_top
  import trace_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  apb_req_t apb;
  trace_evt_t trc = '0;
  logic disarm = 1'b0;
  logic secure = 1'b0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic armed;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  trace_buffer_format_readout DUT (.CLK_I(clk), .RST_I(rst), .APB_I(apb), .TRACE_I(trc),
    .DISARM_I(disarm), .SECURE_I(secure), .PREADY_O(pready), .PRDATA_O(prdata),
    .PSLVERR_O(pslverr), .ARMED_O(armed));
  debug_host_model host (.clk_i(clk), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .apb_o(apb));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
    `CHK(nm, exp, r)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic line(input logic [19:0] row);
    rd(TRACE_DATA_OFS, {16'h0, row[15:0]}, "low word");
    rd(TRACE_DATA_OFS, {28'h0, row[19:16]}, "high word");
  endtask
  task automatic cnt(input logic lk, input logic fl, input logic [6:0] n);
    rd(TRACE_COUNT_OFS, {23'h0, lk, fl, n}, "count");
  endtask
  task automatic ev(input logic [17:0] pc, input logic d, input logic v);
    trc <= '{valid: 1'b1, pc: pc, dest: d, vector: v, size_byte: 1'b0, read: 1'b0,
             data: 16'h0};
    @(posedge clk);
  endtask
  task automatic stop();
    trc.valid <= 1'b0;
    @(posedge clk);
    disarm <= 1'b1;
    @(posedge clk);
    disarm <= 1'b0;
    @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h10, 32'h0, "unmapped");
    rd(TRACE_DATA_HIGH_OFS, 32'h0, "high reg");
    wr(CTRL_OFS, 32'h3);
    ev(18'h2ABCD, 1'b0, 1'b0);
    ev(18'h1FFF2, 1'b1, 1'b1);
    ev(18'h00100, 1'b1, 1'b0);
    stop();
    cnt(1'b1, 1'b0, 7'h03);
    rd(TRACE_DATA_OFS, 32'h0, "locked");
    host.unlock();
    line(20'h2ABCD);
    line(20'hDFFF2);
    line(20'h80100);
    cnt(1'b0, 1'b0, 7'h03);
    wr(TRACE_DATA_HIGH_OFS, 32'h0);
    rd(8'h06, 32'h0, "misaligned");
    line(20'h2ABCD);
    secure <= 1'b1;
    rd(TRACE_DATA_OFS, 32'h0, "secured");
    secure <= 1'b0;
    $display("test normal done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(CTRL_OFS, 32'h2);
    host.unlock();
    cnt(1'b0, 1'b0, 7'h03);
    line(20'h2ABCD);
    wr(CTRL_OFS, 32'h0);
    rd(TRACE_DATA_OFS, 32'h0, "no source");
    $display("test reset done");
    wr(CTRL_OFS, 32'hF);
    for (int i = 0; i < 4; i++) begin
      ev(18'h12340 + 18'(i), 1'b0, 1'b0);
    end
    ev(18'h12380, 1'b0, 1'b0);
    ev(18'h12385, 1'b0, 1'b0);
    stop();
    wr(CTRL_OFS, 32'hE);
    host.unlock();
    cnt(1'b0, 1'b0, 7'h04);
    line(20'h12340);
    line({2'h3, 6'h03, 6'h02, 6'h01});
    line(20'h12380);
    line({2'h1, 12'h0, 6'h05});
    $display("test compressed done");
    wr(CTRL_OFS, 32'h3);
    for (int i = 0; i < 66; i++) begin
      ev(18'(i), 1'b0, 1'b0);
    end
    stop();
    host.unlock();
    cnt(1'b0, 1'b1, 7'h40);
    line(20'h00002);
    line(20'h00003);
    $display("test rollover done");
    wr(CTRL_OFS, 32'h7);
    ev(18'h00500, 1'b0, 1'b0);
    ev(18'h00500, 1'b0, 1'b0);
    ev(18'h00500, 1'b1, 1'b0);
    stop();
    host.unlock();
    cnt(1'b0, 1'b0, 7'h02);
    line(20'h00500);
    line(20'h80500);
    wr(CTRL_OFS, 32'hB);
    trc <= '{valid: 1'b1, pc: 18'h3A5A5, dest: 1'b0, vector: 1'b0, size_byte: 1'b1,
             read: 1'b1, data: 16'hBEEF};
    @(posedge clk);
    stop();
    host.unlock();
    cnt(1'b0, 1'b0, 7'h02);
    line(20'hFA5A5);
    line(20'h0BEEF);
    $display("test loop and detail done");
    wr(CTRL_OFS, 32'hF);
    for (int i = 0; i < 64; i++) begin
      ev(18'(i * 64), 1'b0, 1'b0);
    end
    ev(18'h00FC1, 1'b0, 1'b0);
    ev(18'h00FC2, 1'b0, 1'b0);
    stop();
    host.unlock();
    cnt(1'b0, 1'b1, 7'h40);
    line(20'h00080);
    for (int i = 3; i < 64; i++) begin
      line(20'(i * 64));
    end
    line(20'h00FC1);
    line({2'h1, 12'h0, 6'h02});
    $display("test compressed rollover done");
    end_of_test();
  end
endmodule
